/* File: psg_core_model.sv */
// Behavioural model of the processor core and the wake sources facing the block.
`default_nettype none
module psg_core_model (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Core clock gate coming back from the block.
    input wire logic core_clk_en_i,
    // Instruction and wake requests.
    output logic power_save_instruction_o,
    output logic psave_operand_o,
    output logic irq_enabled_pending_o,
    output logic watchdog_timeout_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Everything starts quiet so no wake source is pending at power-up.
    initial begin
        power_save_instruction_o = 1'b0;
        psave_operand_o = 1'b0;
        irq_enabled_pending_o = 1'b0;
        watchdog_timeout_o = 1'b0;
    end

    // A stopped core cannot execute, so the pulse waits for a running clock.
    task automatic exec_psave(input logic op);
        @(posedge mclk_i);
        while (reset_n_i !== 1'b1 || core_clk_en_i !== 1'b1) @(posedge mclk_i);
        power_save_instruction_o <= 1'b1;
        psave_operand_o <= op;
        @(posedge mclk_i);
        power_save_instruction_o <= 1'b0;
        psave_operand_o <= ~op;
    endtask

    // Wake sources are levels that the bench raises and drops.
    task automatic set_wake(input logic irq, input logic wdt);
        @(posedge mclk_i);
        irq_enabled_pending_o <= irq;
        watchdog_timeout_o <= wdt;
    endtask
endmodule
`default_nettype wire

/* File: psg_osc_select.sv */
// Run-time oscillator source selection, writable while the clock configuration is unlocked.
`default_nettype none
module psg_osc_select #(
    parameter int SEL_W = psg_pkg::OSC_SEL_W
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Software write of the new-oscillator select field.
    input wire logic osc_wr_i,
    input wire logic [SEL_W-1:0] new_osc_select_i,
    input wire logic clk_cfg_locked_i,
    // Currently selected oscillator source.
    output logic [SEL_W-1:0] osc_sel_o
);
    logic [SEL_W-1:0] sel_reg;
    logic [SEL_W-1:0] sel_next;

    // A write only takes effect while the configuration is unlocked.
    always_comb begin
        sel_next = sel_reg;
        if (osc_wr_i && !clk_cfg_locked_i) begin
            sel_next = new_osc_select_i; // [RQ1]
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_reg <= SEL_W'(psg_pkg::OSC_SEL_RST);
        end else begin
            sel_reg <= sel_next;
        end
    end

    assign osc_sel_o = sel_reg;

    // Writes under lock leave the selection alone.
    property p_lock_holds;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (osc_wr_i && clk_cfg_locked_i) |=> $stable(sel_reg);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("locked select changed"); // [RQ1]

    property p_unlocked_write;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (osc_wr_i && !clk_cfg_locked_i) |=> (sel_reg == $past(new_osc_select_i));
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) else $error("select not written"); // [RQ1]
endmodule
`default_nettype wire

/* File: psg_pkg.sv */
// Package of constants and types for the power-save clock gating block.
`default_nettype none
package psg_pkg;
    // Width of the new-oscillator select field of the oscillator control register.
    localparam int OSC_SEL_W = 3;
    // Reset value of the oscillator select (first oscillator source).
    localparam logic [2:0] OSC_SEL_RST = 3'h0;
    // Operand code of the power-save instruction selecting Sleep; any other code means Idle.
    localparam logic SLEEP_OPERAND = 1'h0;
    // Wake latency: cycles the restarted oscillator needs before the core runs again.
    localparam int OSC_START_CYCLES = 4;
    localparam int START_CNT_W = 3;
    // Power states of the block.
    typedef enum logic [1:0] {
        PSG_RUN,
        PSG_IDLE,
        PSG_SLEEP,
        PSG_WAKE
    } psg_state_t;
endpackage
`default_nettype wire

/* File: psg_power_ctrl.sv */
// Sleep and Idle entry and wake control with clock gating for core and peripherals.
// Notes on behaviour
// RQ1: Unlocked clock configuration lets software write the new oscillator select field.
// RQ2: Sleep or Idle entered only by the power-save instruction; operand picks which.
// RQ3: Sleep stops the clocks and halts all instruction execution.
// RQ4: Idle halts the core but peripherals stay clocked.
// RQ5: Enabled interrupt, watchdog time-out or any reset wakes the device.
// RQ6: Sleep shuts down the system clock source and on-chip oscillator.
// RQ7: Fail-safe clock monitor is inactive during Sleep.
// RQ8: Low-power RC clock runs in Sleep when the watchdog is enabled.
// RQ9: Watchdog count is cleared just before Sleep when the watchdog is enabled.
// RQ10: Input change detect and externally clocked peripherals may run in Sleep.
// RQ11: Peripherals needing the system clock are disabled in Sleep.
// RQ12: Wake from Sleep restarts the core on the clock source used before Sleep.
// RQ13: The instruction operand is decoded into a one-bit Sleep or Idle select.
`default_nettype none
module psg_power_ctrl #(
    parameter int SEL_W = psg_pkg::OSC_SEL_W,
    parameter int START_CYCLES = psg_pkg::OSC_START_CYCLES
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Processor core power-save instruction.
    input wire logic power_save_instruction_i,
    input wire logic psave_operand_i,
    // Wake sources and the watchdog enable.
    input wire logic irq_enabled_pending_i,
    input wire logic watchdog_timeout_i,
    input wire logic watchdog_enable_i,
    // Oscillator control register field write.
    input wire logic osc_wr_i,
    input wire logic [SEL_W-1:0] new_osc_select_i,
    input wire logic clk_cfg_locked_i,
    // Clock and gating controls.
    output logic core_clk_en_o,
    output logic periph_clk_en_o,
    output logic sysclk_src_en_o,
    output logic [SEL_W-1:0] active_osc_o,
    output logic fscm_enable_o,
    output logic low_power_rc_clock_en_o,
    output logic watchdog_clear_o,
    output logic input_change_detect_en_o,
    output logic ext_clk_periph_en_o,
    output logic sleeping_o,
    output logic idling_o
);
    psg_pkg::psg_state_t state_reg;
    psg_pkg::psg_state_t state_next;
    logic [psg_pkg::START_CNT_W-1:0] cnt_reg;
    logic [psg_pkg::START_CNT_W-1:0] cnt_next;
    logic [SEL_W-1:0] osc_sel;
    logic [SEL_W-1:0] saved_osc_reg;
    logic [SEL_W-1:0] saved_osc_next;
    logic core_en_reg, core_en_next;
    logic per_en_reg, per_en_next;
    logic src_en_reg, src_en_next;
    logic fscm_reg, fscm_next;
    logic low_power_rc_clock_reg, low_power_rc_clock_next;
    logic wclr_reg, wclr_next;
    logic slp_reg, slp_next;
    logic idl_reg, idl_next;
    logic wake;
    logic osc_wr_gated;
    logic run_en_reg, run_en_next;

    // Operand decode shared by the entry logic.
    function automatic logic is_sleep(input logic operand);
        return operand == psg_pkg::SLEEP_OPERAND; // [RQ13]
    endfunction

    // Oscillator selection register; the gated core cannot write it during Sleep.
    psg_osc_select #(
        .SEL_W(SEL_W)
    ) u_osc_select (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .osc_wr_i(osc_wr_gated),
        .new_osc_select_i(new_osc_select_i),
        .clk_cfg_locked_i(clk_cfg_locked_i),
        .osc_sel_o(osc_sel)
    );

    // Device reset is the asynchronous reset itself, so it wakes by returning to run.
    assign wake = irq_enabled_pending_i || watchdog_timeout_i; // [RQ5]

    // Only a running core can write the select, and never in the cycle it enters a low-power
    // state, so the source saved at Sleep entry is the one the core restarts on.
    assign osc_wr_gated = osc_wr_i && core_en_reg && !power_save_instruction_i; // [RQ12]

    // Next state and gating controls.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        saved_osc_next = saved_osc_reg;
        wclr_next = 1'b0;
        unique case (state_reg)
            psg_pkg::PSG_RUN: begin
                if (power_save_instruction_i) begin // [RQ2]
                    if (is_sleep(psave_operand_i)) begin
                        state_next = psg_pkg::PSG_SLEEP;
                        saved_osc_next = osc_sel; // [RQ12]
                        wclr_next = watchdog_enable_i; // [RQ9]
                    end else begin
                        state_next = psg_pkg::PSG_IDLE;
                    end
                end
            end
            psg_pkg::PSG_IDLE: begin
                if (wake) begin
                    state_next = psg_pkg::PSG_RUN; // [RQ5]
                end
            end
            psg_pkg::PSG_SLEEP: begin
                if (wake) begin
                    state_next = psg_pkg::PSG_WAKE; // [RQ5]
                    cnt_next = '0;
                end
            end
            psg_pkg::PSG_WAKE: begin
                // The restarted oscillator is given time to settle before the core runs.
                if (cnt_reg == psg_pkg::START_CNT_W'(START_CYCLES - 1)) begin
                    state_next = psg_pkg::PSG_RUN;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
        endcase
        slp_next = (state_next == psg_pkg::PSG_SLEEP);
        idl_next = (state_next == psg_pkg::PSG_IDLE);
        core_en_next = (state_next == psg_pkg::PSG_RUN); // [RQ3] [RQ4]
        per_en_next = (state_next == psg_pkg::PSG_RUN) || idl_next; // [RQ4] [RQ11]
        src_en_next = !slp_next; // [RQ6]
        fscm_next = !slp_next && (state_next != psg_pkg::PSG_WAKE); // [RQ7]
        low_power_rc_clock_next = watchdog_enable_i; // [RQ8]
        run_en_next = 1'b1; // [RQ10]
    end

    // State registers.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= psg_pkg::PSG_RUN;
            cnt_reg <= '0;
            saved_osc_reg <= SEL_W'(psg_pkg::OSC_SEL_RST);
            core_en_reg <= 1'b1;
            per_en_reg <= 1'b1;
            src_en_reg <= 1'b1;
            fscm_reg <= 1'b1;
            low_power_rc_clock_reg <= 1'b0;
            run_en_reg <= 1'b0;
            wclr_reg <= 1'b0;
            slp_reg <= 1'b0;
            idl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            saved_osc_reg <= saved_osc_next;
            core_en_reg <= core_en_next;
            per_en_reg <= per_en_next;
            src_en_reg <= src_en_next;
            fscm_reg <= fscm_next;
            low_power_rc_clock_reg <= low_power_rc_clock_next;
            run_en_reg <= run_en_next;
            wclr_reg <= wclr_next;
            slp_reg <= slp_next;
            idl_reg <= idl_next;
        end
    end

    // In run and Idle the live selection drives the source; in Sleep and wake the saved one.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_osc_o <= SEL_W'(psg_pkg::OSC_SEL_RST);
        end else begin
            active_osc_o <= (state_next == psg_pkg::PSG_RUN || idl_next) ?
                osc_sel : saved_osc_next; // [RQ12]
        end
    end

    assign core_clk_en_o = core_en_reg;
    assign periph_clk_en_o = per_en_reg;
    assign sysclk_src_en_o = src_en_reg;
    assign fscm_enable_o = fscm_reg;
    assign low_power_rc_clock_en_o = low_power_rc_clock_reg;
    assign watchdog_clear_o = wclr_reg;
    // Pin-change detect and externally clocked peripherals are allowed to run in every state.
    // The enable is a flop cleared by reset, so these outputs stay registered like the rest.
    assign input_change_detect_en_o = run_en_reg; // [RQ10]
    assign ext_clk_periph_en_o = run_en_reg; // [RQ10]
    assign sleeping_o = slp_reg;
    assign idling_o = idl_reg;

    property p_sleep_entry;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_reg == psg_pkg::PSG_RUN && power_save_instruction_i
            && psave_operand_i == psg_pkg::SLEEP_OPERAND && !wake)
        |=> (sleeping_o && !core_clk_en_o && !periph_clk_en_o && !sysclk_src_en_o);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong"); // [RQ3]

    property p_idle_entry;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_reg == psg_pkg::PSG_RUN && power_save_instruction_i
            && psave_operand_i != psg_pkg::SLEEP_OPERAND)
        |=> (idling_o && !core_clk_en_o && periph_clk_en_o);
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong"); // [RQ4]

    property p_no_spurious;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_reg == psg_pkg::PSG_RUN && !power_save_instruction_i) |=> core_clk_en_o;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("core stopped"); // [RQ2]

    property p_idle_wake;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_reg == psg_pkg::PSG_IDLE && wake) |=> core_clk_en_o;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed"); // [RQ5]

    property p_sleep_wake;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_reg == psg_pkg::PSG_SLEEP && wake) |=> ##[1:8] core_clk_en_o;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake failed"); // [RQ5]

    property p_fscm_off;
        @(posedge mclk_i) disable iff (!reset_n_i)
        sleeping_o |-> !fscm_enable_o;
    endproperty
    a_fscm_off: assert property (p_fscm_off) else $error("monitor on in sleep"); // [RQ7]

    property p_low_power_rc_clock;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (sleeping_o && $past(watchdog_enable_i)) |-> low_power_rc_clock_en_o;
    endproperty
    a_low_power_rc_clock: assert property (p_low_power_rc_clock) else $error("rc clock off"); // [RQ8]

    property p_wdt_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        ($rose(sleeping_o) && $past(watchdog_enable_i)) |-> watchdog_clear_o;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared"); // [RQ9]

    property p_same_osc;
        @(posedge mclk_i) disable iff (!reset_n_i)
        sleeping_o |=> $stable(active_osc_o);
    endproperty
    a_same_osc: assert property (p_same_osc) else $error("oscillator changed"); // [RQ12]
endmodule
`default_nettype wire

/* File: psg_power_ctrl_test.sv */
// Self-checking testbench for the power-save clock gating block.
`default_nettype none
module psg_power_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE = 3;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic watchdog_enable_i = 1'b0;
    logic osc_wr_i = 1'b0;
    logic [2:0] new_osc_select_i = 3'h0;
    logic clk_cfg_locked_i = 1'b0;
    logic instr, op, irq, wdt_to, core, periph, src, fscm, low_power_rc_clock, wclr, icd, ext, sleeping, idling;
    logic [2:0] osc;
    logic [7:0] status;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    // Most gating outputs packed as one word; icd, ext and osc are compared apart.
    assign status = {core, periph, src, fscm, low_power_rc_clock, wclr, sleeping, idling};

    // The 10 MHz clock.
    always #50 mclk_i = ~mclk_i;

    psg_core_model i_psg_core_model (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .core_clk_en_i(core), .power_save_instruction_o(instr), .psave_operand_o(op),
        .irq_enabled_pending_o(irq), .watchdog_timeout_o(wdt_to));

    psg_power_ctrl #(.START_CYCLES(WAKE)) i_psg_power_ctrl (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .power_save_instruction_i(instr), .psave_operand_i(op),
        .irq_enabled_pending_i(irq), .watchdog_timeout_i(wdt_to),
        .watchdog_enable_i(watchdog_enable_i), .osc_wr_i(osc_wr_i),
        .new_osc_select_i(new_osc_select_i), .clk_cfg_locked_i(clk_cfg_locked_i),
        .core_clk_en_o(core), .periph_clk_en_o(periph), .sysclk_src_en_o(src),
        .active_osc_o(osc), .fscm_enable_o(fscm), .low_power_rc_clock_en_o(low_power_rc_clock),
        .watchdog_clear_o(wclr), .input_change_detect_en_o(icd),
        .ext_clk_periph_en_o(ext), .sleeping_o(sleeping), .idling_o(idling));

    // Prints the verdict and ends the run.
    task automatic close_out;
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Compares one word and reports a mismatch at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One write of the select field; an extra edge lets the new source settle.
    task automatic wr_osc(input logic [2:0] sel, input logic lock);
        @(posedge mclk_i);
        osc_wr_i <= 1'b1;
        new_osc_select_i <= sel;
        clk_cfg_locked_i <= lock;
        @(posedge mclk_i);
        osc_wr_i <= 1'b0;
        @(posedge mclk_i);
        #1;
    endtask

    task automatic t_osc;
        wr_osc(3'h5, 1'b0);
        chk({5'h0, osc}, 8'h05);
        wr_osc(3'h2, 1'b1);
        chk({5'h0, osc}, 8'h05);
    endtask

    // Sleep with the watchdog on, a select write while asleep, wake by interrupt.
    task automatic t_sleep_irq;
        @(posedge mclk_i);
        watchdog_enable_i <= 1'b1;
        i_psg_core_model.exec_psave(1'b0);
        #1;
        chk(status, 8'h0e);
        chk({6'h0, icd, ext}, 8'h03);
        @(posedge mclk_i);
        #1;
        chk(status, 8'h0a);
        wr_osc(3'h3, 1'b0);
        chk({osc, status[7:3]}, {3'h5, 5'h01});
        i_psg_core_model.set_wake(1'b1, 1'b0);
        for (int n = 1; n <= WAKE + 2; n++) begin
            @(posedge mclk_i);
            #1;
            if (n == 2 || n == WAKE) chk(status, 8'h28);
            if (n == WAKE + 1) chk(status, 8'hf8);
            if (n == WAKE + 1) chk({5'h0, osc}, 8'h05);
        end
        chk(status, 8'hf8);
        i_psg_core_model.set_wake(1'b0, 1'b0);
    endtask

    // Idle keeps peripherals clocked until a watchdog time-out wakes the core.
    task automatic t_idle_wdt;
        int n;
        n = 0;
        @(posedge mclk_i);
        watchdog_enable_i <= 1'b0;
        i_psg_core_model.exec_psave(1'b1);
        #1;
        chk(status, 8'h71);
        repeat (3) @(posedge mclk_i);
        #1;
        chk(status, 8'h71);
        i_psg_core_model.set_wake(1'b0, 1'b1);
        while (core !== 1'b1 && n < 4) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk(status, 8'hf0);
        i_psg_core_model.set_wake(1'b0, 1'b0);
    endtask

    // Sleep without the watchdog, then a reset in mid-Sleep wakes the device.
    task automatic t_sleep_reset;
        i_psg_core_model.exec_psave(1'b0);
        #1;
        chk(status, 8'h02);
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        #1;
        chk(status, 8'hf0);
        chk({6'h0, icd, ext}, 8'h00);
        @(posedge mclk_i);
        reset_n_i <= 1'b1;
        i_psg_core_model.exec_psave(1'b1);
        #1;
        chk({osc, status[7:3]}, {3'h0, 5'h0e});
    endtask

    // A hang is cut short well beyond the fewer than fifty cycles the run needs.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            close_out;
        end
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge mclk_i);
        chk(status, 8'hf0);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        #1;
        chk(status, 8'hf0);
        chk({6'h0, icd, ext}, 8'h03);
        t_osc;
        t_sleep_irq;
        t_idle_wdt;
        t_sleep_reset;
        close_out;
    end
endmodule
`default_nettype wire
